// ---- src/anp_pkg.sv ----
/*
 * Shared constants of the per-port negotiation page registers:
 * register indices, field positions, write masks and reset values.
 * Assumes a 5-bit register index from the management port and 16-bit data.
 */
package anp_pkg;

    localparam int unsigned NUM_PORTS = 4;
    localparam int unsigned DATA_W    = 16;
    localparam int unsigned ADDR_W    = 5;

    // Register indices: the revision register, then the first port of each bank
    localparam logic [4:0] ADDR_REVISION    = 5'h0d;
    localparam logic [4:0] ADDR_ADVERT_BASE = 5'h0e;
    localparam logic [4:0] ADDR_PARTNER_BASE = 5'h12;
    localparam logic [4:0] ADDR_EXPAN_BASE  = 5'h16;
    localparam logic [4:0] ADDR_NPTX_BASE   = 5'h1a;

    // Advertisement and partner ability fields
    localparam int unsigned BIT_NEXT_PAGE_REQUEST = 15;
    localparam int unsigned BIT_PARTNER_ACK       = 14;
    localparam int unsigned BIT_REMOTE_FAULT      = 13;
    localparam int unsigned BIT_FULL_DUPLEX       = 6;
    localparam int unsigned BIT_HALF_DUPLEX       = 5;
    localparam int unsigned SELECTOR_MSB          = 4;

    // Expansion fields
    localparam int unsigned BIT_PD_FAULT          = 4;
    localparam int unsigned BIT_PARTNER_NP_ABLE   = 3;
    localparam int unsigned BIT_LOCAL_NP_ABLE     = 2;
    localparam int unsigned BIT_NEW_PAGE          = 1;
    localparam int unsigned BIT_PARTNER_AN_ABLE   = 0;

    // Next-page transmit fields
    localparam int unsigned BIT_LAST_PAGE         = 15;
    localparam int unsigned BIT_MESSAGE_PAGE      = 13;
    localparam int unsigned BIT_WILL_COMPLY       = 12;
    localparam int unsigned BIT_PARITY            = 11;
    localparam int unsigned CODE_MSB              = 10;

    // Writable bits and partner capture bits
    localparam logic [15:0] ADVERT_WR_MASK  = 16'ha060;
    localparam logic [15:0] PARTNER_MASK    = 16'he07f;
    localparam logic [15:0] NPTX_WR_MASK    = 16'hb7ff;

    // Reset values
    localparam logic [15:0] ADVERT_RESET    = 16'h0060;
    localparam logic [15:0] PARTNER_RESET   = 16'h0000;
    localparam logic [15:0] NPTX_RESET      = 16'h8001;
    localparam logic        LOCAL_NP_ABLE   = 1'b1;

endpackage : anp_pkg

// ---- src/anp_port_if.sv ----
/*
 * Carrier between the register bank top and one per-port register slice.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface anp_port_if;
    logic        wr_advert;
    logic        wr_nptx;
    logic        rd_expan;
    logic [15:0] wdata;
    logic        page_valid;
    logic        page_base;
    logic [15:0] page_word;
    logic        pd_fault;
    logic        partner_an_able;
    logic        tx_done;
    logic        tx_parity;
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] expan;
    logic [15:0] nptx;

    modport slice (
        input  wr_advert, wr_nptx, rd_expan, wdata,
        input  page_valid, page_base, page_word, pd_fault, partner_an_able,
        input  tx_done, tx_parity,
        output advert, partner, expan, nptx
    );
    modport bank (
        output wr_advert, wr_nptx, rd_expan, wdata,
        output page_valid, page_base, page_word, pd_fault, partner_an_able,
        output tx_done, tx_parity,
        input  advert, partner, expan, nptx
    );
endinterface : anp_port_if

`default_nettype wire

// ---- src/anp_port_regs.sv ----
/*
 * One port's advertisement, partner ability, expansion and next-page
 * transmit registers. Assumes strobes are one-cycle pulses on the core clock
 * and that negotiation events come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module anp_port_regs
    import anp_pkg::*;
(
    // Clock and reset
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    // Bank side
    anp_port_if.slice   port
);

    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] nptx;
    logic        new_page;
    logic        partner_np_able;
    logic        prev_parity;
    logic [15:0] next_advert;
    logic [15:0] next_partner;
    logic [15:0] next_nptx;
    logic        next_new_page;
    logic        next_partner_np_able;
    logic        next_prev_parity;

    always_comb begin
        next_advert          = advert;
        next_nptx            = nptx;
        next_partner         = partner;
        next_new_page        = new_page;
        next_partner_np_able = partner_np_able;
        next_prev_parity     = prev_parity;
        // Only writable bits stored; strap levels never enter here
        if (port.wr_advert) begin
            next_advert = port.wdata & ADVERT_WR_MASK;
        end
        if (port.wr_nptx) begin
            next_nptx = port.wdata & NPTX_WR_MASK;
        end
        // Read clears, but a page arriving the same cycle wins
        if (port.rd_expan) begin
            next_new_page = 1'b0;
        end
        if (port.page_valid) begin
            next_new_page = 1'b1;
            if (port.page_base) begin
                next_partner         = port.page_word & PARTNER_MASK;
                next_partner_np_able = port.page_word[BIT_NEXT_PAGE_REQUEST];
            end
        end
        if (port.tx_done) begin
            next_prev_parity = port.tx_parity;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            advert          <= ADVERT_RESET;
            partner         <= PARTNER_RESET;
            nptx            <= NPTX_RESET;
            new_page        <= 1'b0;
            partner_np_able <= 1'b0;
            prev_parity     <= 1'b0;
        end else begin
            advert          <= next_advert;
            partner         <= next_partner;
            nptx            <= next_nptx;
            new_page        <= next_new_page;
            partner_np_able <= next_partner_np_able;
            prev_parity     <= next_prev_parity;
        end
    end

    always_comb begin
        port.expan                      = '0;
        port.expan[BIT_PD_FAULT]        = port.pd_fault;
        port.expan[BIT_PARTNER_NP_ABLE] = partner_np_able;
        port.expan[BIT_LOCAL_NP_ABLE]   = LOCAL_NP_ABLE;
        port.expan[BIT_NEW_PAGE]        = new_page;
        port.expan[BIT_PARTNER_AN_ABLE] = port.partner_an_able;
        port.nptx                       = nptx;
        port.nptx[BIT_PARITY]           = ~prev_parity;
    end

    assign port.advert  = advert;
    assign port.partner = partner;

endmodule : anp_port_regs

`default_nettype wire

// ---- src/anp_reg_bank.sv ----
/*
 * Negotiation page register bank for four ports plus the chip-wide silicon
 * revision register, reached over the management register port.
 * Assumes the serial management front end presents one-cycle read and write
 * strobes with a 5-bit register index, and that the negotiation engine runs
 * on the same clock.
 */
// Summary of operation
// - Read-only chip revision register, writes ignored
// - Four advertisement registers, consecutive, form sent word
// - Advertisement top bit requests next-page exchange
// - Advertisement bit announces locally detected remote fault
// - Advertisement full and half duplex capability bits
// - Duplex straps never change advertised duplex
// - Read-only partner ability capture per port
// - Partner acknowledge bit shows partner received word
// - Expansion shows parallel detection fault
// - Expansion shows partner next-page ability
// - Expansion shows local next-page ability
// - New page flag sets on arrival, read clears
// - Expansion shows partner auto-negotiation ability
// - Next-page top bit: one means last page
// - Next-page message page flag
// - Next-page will comply flag
// - Parity bit reads inverse of previous word's
// - Next-page eleven-bit writable code field
`timescale 1ns/1ps
`default_nettype none

module anp_reg_bank
    import anp_pkg::*;
#(
    // Arbitrary neutral revision value
    parameter logic [15:0] SILICON_REV = 16'h00a5
) (
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_rst,
    // Management register port
    input  wire logic [4:0]         i_reg_addr,
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire logic [15:0]        i_reg_wdata,
    output logic      [15:0]        o_reg_rdata,
    // Negotiation engine, per port
    input  wire logic [3:0]         i_page_valid,
    input  wire logic [3:0]         i_page_base,
    input  wire logic [3:0][15:0]   i_page_word,
    input  wire logic [3:0]         i_pd_fault,
    input  wire logic [3:0]         i_partner_an_able,
    input  wire logic [3:0]         i_tx_done,
    input  wire logic [3:0]         i_tx_parity,
    // Words for the negotiation engine to send
    output logic      [3:0][15:0]   o_advert_word,
    output logic      [3:0][15:0]   o_nptx_word
);

    // Bank hit and port index for a four-register bank
    function automatic logic [2:0] bank_hit(input logic [4:0] addr, input logic [4:0] base);
        logic [4:0] off;
        off = addr - base;
        bank_hit = {(addr >= base) && (off < 5'd4), off[1:0]};
    endfunction : bank_hit

    logic [2:0]        hit_adv;
    logic [2:0]        hit_par;
    logic [2:0]        hit_exp;
    logic [2:0]        hit_npt;
    logic [3:0][15:0]  advert_q;
    logic [3:0][15:0]  partner_q;
    logic [3:0][15:0]  expan_q;
    logic [3:0][15:0]  nptx_q;
    logic [15:0]       rd_value;
    logic [15:0]       next_rdata;

    assign hit_adv = bank_hit(i_reg_addr, ADDR_ADVERT_BASE);
    assign hit_par = bank_hit(i_reg_addr, ADDR_PARTNER_BASE);
    assign hit_exp = bank_hit(i_reg_addr, ADDR_EXPAN_BASE);
    assign hit_npt = bank_hit(i_reg_addr, ADDR_NPTX_BASE);

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            anp_port_if pif ();

            assign pif.wr_advert       = i_reg_wr && hit_adv[2] && (hit_adv[1:0] == 2'(p));
            assign pif.wr_nptx         = i_reg_wr && hit_npt[2] && (hit_npt[1:0] == 2'(p));
            assign pif.rd_expan        = i_reg_rd && hit_exp[2] && (hit_exp[1:0] == 2'(p));
            assign pif.wdata           = i_reg_wdata;
            assign pif.page_valid      = i_page_valid[p];
            assign pif.page_base       = i_page_base[p];
            assign pif.page_word       = i_page_word[p];
            assign pif.pd_fault        = i_pd_fault[p];
            assign pif.partner_an_able = i_partner_an_able[p];
            assign pif.tx_done         = i_tx_done[p];
            assign pif.tx_parity       = i_tx_parity[p];
            assign advert_q[p]         = pif.advert;
            assign partner_q[p]        = pif.partner;
            assign expan_q[p]          = pif.expan;
            assign nptx_q[p]           = pif.nptx;

            anp_port_regs u_port (
                .i_core_clk (i_core_clk),
                .i_rst      (i_rst),
                .port       (pif.slice)
            );
        end
    endgenerate

    // Read mux; unmapped and reserved read as zero
    always_comb begin
        if (i_reg_addr == ADDR_REVISION) begin
            rd_value = SILICON_REV;
        end else if (hit_adv[2]) begin
            rd_value = advert_q[hit_adv[1:0]];
        end else if (hit_par[2]) begin
            rd_value = partner_q[hit_par[1:0]];
        end else if (hit_exp[2]) begin
            rd_value = expan_q[hit_exp[1:0]];
        end else if (hit_npt[2]) begin
            rd_value = nptx_q[hit_npt[1:0]];
        end else begin
            rd_value = '0;
        end
        next_rdata = i_reg_rd ? rd_value : o_reg_rdata;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
        end else begin
            o_reg_rdata <= next_rdata;
        end
    end

    assign o_advert_word = advert_q;
    assign o_nptx_word   = nptx_q;

endmodule : anp_reg_bank

`default_nettype wire

// ---- dv/anp_bank_assertions.sv ----
/* Port checks of the negotiation register bank, lane 0 plus all-lane advert hold.
   Bound to anp_reg_bank; one clock, async high reset. */
`timescale 1ns/1ps
`default_nettype none
module anp_bank_assertions
    import anp_pkg::*;
#(
    parameter logic [15:0] SILICON_REV = 16'h00a5
) (
    input wire logic             i_core_clk,
    input wire logic             i_rst,
    input wire logic [4:0]       i_reg_addr,
    input wire logic             i_reg_wr,
    input wire logic             i_reg_rd,
    input wire logic [15:0]      i_reg_wdata,
    input wire logic [15:0]      o_reg_rdata,
    input wire logic [3:0]       i_page_valid,
    input wire logic [3:0]       i_pd_fault,
    input wire logic [3:0]       i_partner_an_able,
    input wire logic [3:0]       i_tx_done,
    input wire logic [3:0]       i_tx_parity,
    input wire logic [3:0][15:0] o_advert_word,
    input wire logic [3:0][15:0] o_nptx_word
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence rd_expan0;
        i_reg_rd && i_reg_addr == 5'h16 && !i_page_valid[0];
    endsequence
    sequence page_then_read;
        i_page_valid[0] ##1 !i_reg_rd ##1 rd_expan0;
    endsequence
    chk_rev_read: assert property (i_reg_rd && i_reg_addr == 5'h0d |=> o_reg_rdata == SILICON_REV)
        else $error("revision read wrong");
    chk_advert_write: assert property (i_reg_wr && i_reg_addr == 5'h0e
        |=> o_advert_word[0] == ($past(i_reg_wdata) & 16'ha060))
        else $error("advert write wrong");
    chk_advert_hold: assert property (!(i_reg_wr && i_reg_addr inside {[5'h0e:5'h11]})
        |=> $stable(o_advert_word))
        else $error("advert changed");
    chk_nptx_write: assert property (i_reg_wr && i_reg_addr == 5'h1a && !i_tx_done[0]
        |=> (o_nptx_word[0] & 16'hb7ff) == ($past(i_reg_wdata) & 16'hb7ff))
        else $error("nptx write wrong");
    chk_parity_flip: assert property (i_tx_done[0] |=> o_nptx_word[0][11] == !$past(i_tx_parity[0]))
        else $error("parity bit wrong");
    chk_new_page: assert property (page_then_read |=> o_reg_rdata[1])
        else $error("new page flag missing");
    chk_expan_live: assert property (rd_expan0 |=> o_reg_rdata[4] == $past(i_pd_fault[0])
        && o_reg_rdata[0] == $past(i_partner_an_able[0]) && o_reg_rdata[2])
        else $error("expansion status wrong");
    chk_partner_resv: assert property (i_reg_rd && i_reg_addr == 5'h12
        |=> (o_reg_rdata & 16'h1f80) == 16'h0000)
        else $error("partner reserved bits set");
    chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved");
endmodule : anp_bank_assertions
bind anp_reg_bank anp_bank_assertions #(.SILICON_REV(SILICON_REV)) anp_bank_assertions_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_page_valid(i_page_valid), .i_pd_fault(i_pd_fault), .i_partner_an_able(i_partner_an_able),
    .i_tx_done(i_tx_done), .i_tx_parity(i_tx_parity), .o_advert_word(o_advert_word),
    .o_nptx_word(o_nptx_word));
`default_nettype wire

// ---- dv/anp_link_partner.sv ----
/* Remote partner model: pages, transmit completions and status levels.
   Tasks are called from the core clock domain. */
`timescale 1ns/1ps
`default_nettype none
module anp_link_partner (
    // Clock
    input  wire logic             i_core_clk,
    // Negotiation engine side
    output var logic [3:0]       o_page_valid,
    output var logic [3:0]       o_page_base,
    output var logic [3:0][15:0] o_page_word,
    output var logic [3:0]       o_pd_fault,
    output var logic [3:0]       o_an_able,
    output var logic [3:0]       o_tx_done,
    output var logic [3:0]       o_tx_parity
);
    initial begin
        o_page_valid = '0;
        o_page_base = '0;
        o_page_word = '0;
        o_pd_fault = '0;
        o_an_able = '0;
        o_tx_done = '0;
        o_tx_parity = '0;
    end
    task automatic send_page(input int p, input logic base, input logic [15:0] word);
        @(posedge i_core_clk);
        o_page_valid[p] <= 1'h1;
        o_page_base[p] <= base;
        o_page_word[p] <= word;
        @(posedge i_core_clk);
        o_page_valid[p] <= 1'h0;
        // Word not held past its strobe
        o_page_word[p] <= ~word;
    endtask : send_page
    task automatic send_tx(input int p, input logic parity);
        @(posedge i_core_clk);
        o_tx_done[p] <= 1'h1;
        o_tx_parity[p] <= parity;
        @(posedge i_core_clk);
        o_tx_done[p] <= 1'h0;
        o_tx_parity[p] <= ~parity;
    endtask : send_tx
    task automatic set_status(input int p, input logic pd, input logic able);
        @(posedge i_core_clk);
        o_pd_fault[p] <= pd;
        o_an_able[p] <= able;
    endtask : set_status
endmodule : anp_link_partner
`default_nettype wire

// ---- dv/testbench.sv ----
/* Self-checking bench of the negotiation register bank.
   Drives the register port; partner model drives the engine side. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import anp_pkg::*;
    // Arbitrary revision value
    localparam logic [15:0] REV = 16'h00a5;
    logic             i_core_clk, i_rst, i_reg_wr, i_reg_rd;
    logic [4:0]       i_reg_addr;
    logic [15:0]      i_reg_wdata, o_reg_rdata;
    logic [3:0]       pv, pb, pd, ab, td, tp;
    logic [3:0][15:0] pw, o_advert_word, o_nptx_word;
    int               num_errors, checks;
    anp_reg_bank #(.SILICON_REV(REV)) anp_reg_bank_inst (.i_core_clk(i_core_clk), .i_rst(i_rst),
        .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .i_page_valid(pv), .i_page_base(pb), .i_page_word(pw),
        .i_pd_fault(pd), .i_partner_an_able(ab), .i_tx_done(td), .i_tx_parity(tp),
        .o_advert_word(o_advert_word), .o_nptx_word(o_nptx_word));
    anp_link_partner anp_link_partner_inst (.i_core_clk(i_core_clk), .o_page_valid(pv),
        .o_page_base(pb), .o_page_word(pw), .o_pd_fault(pd), .o_an_able(ab), .o_tx_done(td),
        .o_tx_parity(tp));
    initial begin
        i_core_clk = 1'h0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic conclude();
        if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask : check
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'h1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'h0;
    endtask : reg_wr
    task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
        @(posedge i_core_clk);
        i_reg_rd <= 1'h1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'h0;
        #1 check($sformatf("reg %h", a), exp, o_reg_rdata);
    endtask : rd_chk
    task automatic t_reset_vals();
        rd_chk(5'h0d, REV);
        rd_chk(5'h00, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            rd_chk(5'h0e + 5'(p), 16'h0060);
            rd_chk(5'h12 + 5'(p), 16'h0000);
            rd_chk(5'h1a + 5'(p), 16'h8801);
        end
    endtask : t_reset_vals
    task automatic t_advert();
        reg_wr(5'h0d, 16'hffff);
        rd_chk(5'h0d, REV);
        for (int p = 0; p < 4; p++) begin
            reg_wr(5'h0e + 5'(p), 16'hffff);
            rd_chk(5'h0e + 5'(p), 16'ha060);
            check("advert word", 16'ha060, o_advert_word[p]);
            reg_wr(5'h0e + 5'(p), 16'h0000);
            rd_chk(5'h0e + 5'(p), 16'h0000);
        end
    endtask : t_advert
    task automatic t_partner();
        for (int p = 0; p < 4; p++) begin
            anp_link_partner_inst.send_page(p, 1'h1, 16'hffff);
            rd_chk(5'h12 + 5'(p), 16'he07f);
            reg_wr(5'h12 + 5'(p), 16'h0000);
            rd_chk(5'h16 + 5'(p), 16'h000e);
            rd_chk(5'h16 + 5'(p), 16'h000c);
            anp_link_partner_inst.send_page(p, 1'h0, 16'h0000);
            rd_chk(5'h16 + 5'(p), 16'h000e);
            rd_chk(5'h12 + 5'(p), 16'he07f);
        end
    endtask : t_partner
    // Page arrival and flag read in one cycle
    task automatic t_page_race();
        fork
            anp_link_partner_inst.send_page(0, 1'h0, 16'h0000);
            rd_chk(5'h16, 16'h000c);
        join
        rd_chk(5'h16, 16'h000e);
    endtask : t_page_race
    // Reset in mid-run restores the four registers of port 0
    task automatic t_mid_reset();
        reg_wr(5'h0e, 16'hffff);
        @(posedge i_core_clk);
        i_rst <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        i_rst <= 1'h0;
        rd_chk(5'h0e, 16'h0060);
        rd_chk(5'h12, 16'h0000);
        rd_chk(5'h16, 16'h0004);
        rd_chk(5'h1a, 16'h8801);
    endtask : t_mid_reset
    task automatic t_expan();
        for (int p = 0; p < 4; p++) begin
            anp_link_partner_inst.set_status(p, 1'h1, 1'h1);
            rd_chk(5'h16 + 5'(p), 16'h001d);
            anp_link_partner_inst.set_status(p, 1'h0, 1'h0);
            rd_chk(5'h16 + 5'(p), 16'h000c);
        end
    endtask : t_expan
    task automatic t_nptx();
        for (int p = 0; p < 4; p++) begin
            reg_wr(5'h1a + 5'(p), 16'hffff);
            rd_chk(5'h1a + 5'(p), 16'hbfff);
            check("nptx word", 16'hbfff, o_nptx_word[p]);
            anp_link_partner_inst.send_tx(p, 1'h1);
            rd_chk(5'h1a + 5'(p), 16'hb7ff);
            reg_wr(5'h1a + 5'(p), 16'h0000);
            rd_chk(5'h1a + 5'(p), 16'h0000);
            anp_link_partner_inst.send_tx(p, 1'h0);
            rd_chk(5'h1a + 5'(p), 16'h0800);
        end
    endtask : t_nptx
    initial begin
        repeat (20000) @(posedge i_core_clk);
        num_errors++;
        conclude();
    end
    initial begin
        num_errors = 0;
        checks = 0;
        i_rst = 1'h1;
        i_reg_wr = 1'h0;
        i_reg_rd = 1'h0;
        i_reg_addr = 5'h00;
        i_reg_wdata = 16'h0000;
        repeat (16) @(posedge i_core_clk);
        i_rst <= 1'h0;
        t_reset_vals();
        t_advert();
        t_partner();
        t_expan();
        t_page_race();
        t_nptx();
        t_mid_reset();
        conclude();
    end
endmodule : testbench
`default_nettype wire
